// >>> include/eeprom_pkg.sv
// Purpose: shared types for the two-wire serial memory target
// Assumes: constants come from eeprom_regs.svh
// Notes:   phase codes are one-hot
`include "eeprom_regs.svh"

package eeprom_pkg;

  // bus phases of the target, one-hot
  typedef enum logic [8:0] {
    ST_IDLE     = 9'h001,
    ST_DEV      = 9'h002,
    ST_DEV_ACK  = 9'h004,
    ST_WORD     = 9'h008,
    ST_WORD_ACK = 9'h010,
    ST_DATA     = 9'h020,
    ST_DATA_ACK = 9'h040,
    ST_READ     = 9'h080,
    ST_READ_ACK = 9'h100
  } phase_t;

  // one queued array write
  typedef struct packed {
    logic                 wp;
    logic [`ADDR_W-1:0]   addr;
    logic [7:0]           data;
  } wr_word_t;

  // whole state of the target
  typedef struct packed {
    phase_t               phase;
    logic [1:0]           scl_sync;
    logic [1:0]           sda_sync;
    logic [1:0]           strap_sync;
    logic [1:0]           wp_sync;
    logic                 scl_q;
    logic                 sda_q;
    logic [7:0]           shift;
    logic [3:0]           bit_cnt;
    logic [`ADDR_W-1:0]   addr;
    logic [7:0]           rd_byte;
    logic                 rnw;
    logic                 mack;
    logic                 sda_oe;
    logic                 wr_pending;
    logic [`BUSY_W-1:0]   busy_cnt;
  } state_t;

endpackage

// >>> include/eeprom_regs.svh
// Purpose: named constants for the two-wire serial memory target
// Assumes: 100 MHz system clock, byte-wide array of 1024 locations
// Notes:   included by the package; definitions only
`ifndef EEPROM_REGS_SVH
`define EEPROM_REGS_SVH

`define CLK_PERIOD_NS   10
`define WR_TIME_NS      5000000
`define BUSY_W          19
`define DEV_FAMILY      4'hA
`define ADDR_W          10
`define MEM_DEPTH       1024
`define PAGE_BITS       4
`define BITS_PER_BYTE   4'h8
`define BIT_CNT_ONE     4'h1
`define FIFO_DEPTH      8

`endif

// >>> include/stream_if.sv
// Purpose: valid/ready word carrier between the target and its queue
// Assumes: one clock domain
// Notes:   data is meaningful only while valid is high
interface stream_if #(parameter int W = 8);
  logic         valid;
  logic         ready;
  logic [W-1:0] data;
  modport src (output valid, output data, input ready);
  modport snk (input valid, input data, output ready);
endinterface

// >>> rtl/byte_fifo.sv
// Purpose: small queue of words with valid/ready on both sides
// Assumes: DEPTH is a power of two
// Notes:   full/empty from pointers with one extra wrap bit
module byte_fifo #(
  parameter int W     = 8,
  parameter int DEPTH = 8
) (
  input  wire logic i_clock,   // system clock
  input  wire logic i_reset,   // synchronous, active high
  stream_if.snk     in_s,      // filling side
  stream_if.src     out_s      // draining side
);
  localparam int AW = $clog2(DEPTH);

  typedef struct packed {
    logic [AW:0] wr;
    logic [AW:0] rd;
  } fifo_state_t;

  fifo_state_t  s;
  fifo_state_t  n;
  logic [W-1:0] mem [DEPTH];
  logic         full;
  logic         empty;

  // extra wrap bit tells full from empty
  assign full        = (s.wr[AW] != s.rd[AW]) && (s.wr[AW-1:0] == s.rd[AW-1:0]);
  assign empty       = (s.wr == s.rd);
  assign in_s.ready  = !full;
  assign out_s.valid = !empty;
  assign out_s.data  = mem[s.rd[AW-1:0]];

  // pointer advance on each accepted transfer
  always_comb begin
    n = s;
    if (in_s.valid && !full) begin
      n.wr = s.wr + 1'b1;
    end
    if (out_s.ready && !empty) begin
      n.rd = s.rd + 1'b1;
    end
  end

  always_ff @(posedge i_clock) begin
    if (i_reset) begin
      s <= '0;
    end else begin
      s <= n;
    end
  end

  // storage carries no reset, pointers guard it
  always_ff @(posedge i_clock) begin
    if (in_s.valid && !full) begin
      mem[s.wr[AW-1:0]] <= in_s.data;
    end
  end
endmodule

// >>> rtl/twowire_eeprom.sv
// Purpose: two-wire bus target with a 1024 x 8 byte array
// Assumes: pins arrive asynchronous and are synchronised here
// Notes:   open-drain data pin; incoming writes queue ahead of the array
`include "eeprom_regs.svh"

// Contract
// - sample command and write data on clock rise
// - change returned data only after clock fall
// - data pin only pulls low or releases
// - protect high blocks every array write
// - respond only when address bit matches strap
// - undriven strap or protect reads as low
// - array is 1024 bytes, ten-bit address
// - page writes up to 16 bytes, partial allowed
// - self-timed programming ends within 5 ms
// - works at 100 kHz, 400 kHz, 1 MHz
// - random and sequential reads supported
module twowire_eeprom
  import eeprom_pkg::*;
#(
  parameter int P_WRITE_CYCLES = `WR_TIME_NS / `CLK_PERIOD_NS
) (
  input  wire logic i_clock,             // 100 MHz system clock
  input  wire logic i_reset,             // synchronous, active high
  input  wire logic i_scl,               // serial clock pin
  input  wire logic i_sda,               // serial data pin, sensed level
  input  wire logic i_addr_select_strap, // device select strap
  input  wire logic i_write_protect,     // array write protect
  output logic      o_sda_out,           // data pin drive value
  output logic      o_sda_oe,            // data pin pull-low enable
  output logic      o_write_busy         // programming in progress
);
  localparam logic [`BUSY_W-1:0] WR_CYCLES = `BUSY_W'(P_WRITE_CYCLES);

  state_t    s;
  state_t    n;
  logic [7:0] mem [`MEM_DEPTH];
  logic       scl;
  logic       sda;
  logic       scl_rise;
  logic       scl_fall;
  logic       start_det;
  logic       stop_det;
  logic       load_rd;
  logic [7:0] rd_word;
  wr_word_t   push_word;
  wr_word_t   pop_word;

  stream_if #(.W($bits(wr_word_t))) push_s ();
  stream_if #(.W($bits(wr_word_t))) pop_s ();

  // queue between bus and array; a full queue nacks the data byte
  byte_fifo #(.W($bits(wr_word_t)), .DEPTH(`FIFO_DEPTH)) u_fifo (
    .i_clock (i_clock),
    .i_reset (i_reset),
    .in_s    (push_s),
    .out_s   (pop_s)
  );

  // bus events from synchronised pins; 1 MHz clock still gives 40+ samples high
  assign scl       = s.scl_sync[1];
  assign sda       = s.sda_sync[1];
  assign scl_rise  = scl && !s.scl_q;
  assign scl_fall  = !scl && s.scl_q;
  assign start_det = scl && s.scl_q && s.sda_q && !sda;
  assign stop_det  = scl && s.scl_q && !s.sda_q && sda;
  assign rd_word   = mem[s.addr];
  assign pop_word  = pop_s.data;

  // array read port is shared, so the queue waits while a byte is fetched
  assign pop_s.ready    = !load_rd;
  assign push_s.data    = push_word;
  assign o_sda_out      = 1'b0;
  assign o_sda_oe       = s.sda_oe;
  assign o_write_busy   = (s.busy_cnt != '0);

  // next-state logic of the whole target
  always_comb begin
    n            = s;
    load_rd      = 1'b0;
    push_s.valid = 1'b0;
    push_word    = '{wp: s.wp_sync[1], addr: s.addr, data: s.shift};
    // strap and protect rely on pin pull-downs, so floating reads low
    n.scl_sync   = {s.scl_sync[0], i_scl};
    n.sda_sync   = {s.sda_sync[0], i_sda};
    n.strap_sync = {s.strap_sync[0], i_addr_select_strap};
    n.wp_sync    = {s.wp_sync[0], i_write_protect};
    n.scl_q      = scl;
    n.sda_q      = sda;
    if (s.busy_cnt != '0) begin
      n.busy_cnt = s.busy_cnt - 1'b1;
    end
    if (start_det) begin
      n.phase   = ST_DEV;
      n.bit_cnt = '0;
      n.sda_oe  = 1'b0;
    end else if (stop_det) begin
      n.phase  = ST_IDLE;
      n.sda_oe = 1'b0;
      if (s.wr_pending) begin
        n.busy_cnt   = WR_CYCLES;
        n.wr_pending = 1'b0;
      end
    end else begin
      case (s.phase)
        ST_IDLE: begin
          n.sda_oe = 1'b0;
        end
        ST_DEV, ST_WORD, ST_DATA: begin
          if (scl_rise) begin
            n.shift   = {s.shift[6:0], sda};
            n.bit_cnt = s.bit_cnt + 1'b1;
          end else if (scl_fall && s.bit_cnt == `BITS_PER_BYTE) begin
            n.bit_cnt = '0;
            if (s.phase == ST_DEV) begin
              // family code, strap bit, then two high address bits
              if (s.shift[7:4] == `DEV_FAMILY && s.shift[3] == s.strap_sync[1]
                  && s.busy_cnt == '0) begin
                n.sda_oe    = 1'b1;
                n.phase     = ST_DEV_ACK;
                n.rnw       = s.shift[0];
                n.addr[9:8] = s.shift[2:1];
              end else begin
                n.phase = ST_IDLE;
              end
            end else if (s.phase == ST_WORD) begin
              n.addr[7:0] = s.shift;
              n.sda_oe    = 1'b1;
              n.phase     = ST_WORD_ACK;
            end else begin
              push_s.valid = 1'b1;
              n.phase      = ST_DATA_ACK;
              if (push_s.ready) begin
                n.sda_oe = 1'b1;
                // roll within the 16-byte page
                n.addr[`PAGE_BITS-1:0] = s.addr[`PAGE_BITS-1:0] + 1'b1;
                if (!s.wp_sync[1]) begin
                  n.wr_pending = 1'b1;
                end
              end
            end
          end
        end
        ST_DEV_ACK: begin
          if (scl_fall) begin
            n.sda_oe = 1'b0;
            n.phase  = ST_WORD;
            load_rd  = s.rnw;
          end
        end
        ST_WORD_ACK, ST_DATA_ACK: begin
          if (scl_fall) begin
            n.sda_oe = 1'b0;
            n.phase  = ST_DATA;
          end
        end
        ST_READ: begin
          if (scl_fall) begin
            if (s.bit_cnt == `BITS_PER_BYTE) begin
              n.sda_oe = 1'b0;            // release for controller ack
              n.phase  = ST_READ_ACK;
            end else begin
              n.sda_oe  = !s.rd_byte[6];
              n.rd_byte = {s.rd_byte[6:0], 1'b0};
              n.bit_cnt = s.bit_cnt + 1'b1;
            end
          end
        end
        ST_READ_ACK: begin
          if (scl_rise) begin
            n.mack = !sda;
          end else if (scl_fall) begin
            load_rd = s.mack;
            if (!s.mack) begin
              n.phase = ST_IDLE;
            end
          end
        end
        default: begin
          n.phase  = ST_IDLE;
          n.sda_oe = 1'b0;
        end
      endcase
    end
    // fetch next byte; full-width address wraps for sequential reads
    if (load_rd) begin
      n.rd_byte = rd_word;
      n.addr    = s.addr + 1'b1;
      n.sda_oe  = !rd_word[7];
      n.bit_cnt = `BIT_CNT_ONE;
      n.phase   = ST_READ;
    end
  end

  // pins idle high, so edge history starts high: no false edge after reset
  always_ff @(posedge i_clock) begin
    if (i_reset) begin
      s <= '{phase: ST_IDLE, scl_sync: '1, sda_sync: '1, scl_q: 1'h1, sda_q: 1'h1, default: '0};
    end else begin
      s <= n;
    end
  end

  // array write from the queue, skipped for protected bytes
  always_ff @(posedge i_clock) begin
    if (pop_s.valid && pop_s.ready && !pop_word.wp) begin
      mem[pop_word.addr] <= pop_word.data;
    end
  end

  default clocking cb @(posedge i_clock); endclocking
  default disable iff (i_reset);

  capture_on_rise_a: assert property ((s.phase == ST_DEV) && scl_rise && !start_det && !stop_det
    |=> s.shift[0] == $past(sda)) else $error("bit not captured on clock rise");
  drive_after_fall_a: assert property ($changed(s.sda_oe)
    |-> $past(scl_fall || start_det || stop_det)) else $error("data pin moved off a fall");
  idle_released_a: assert property ((s.phase == ST_IDLE) |-> !o_sda_oe && !o_sda_out)
    else $error("data pin held while idle");
  protect_block_a: assert property (pop_s.valid && pop_s.ready && pop_word.wp
    |=> mem[$past(pop_word.addr)] == $past(mem[pop_word.addr])) else $error("protected byte written");
  strap_mismatch_a: assert property ((s.phase == ST_DEV) && scl_fall && !start_det && !stop_det
    && s.bit_cnt == `BITS_PER_BYTE && s.shift[3] != s.strap_sync[1]
    |=> !s.sda_oe && s.phase == ST_IDLE) else $error("acked a foreign strap");
  busy_nack_a: assert property ((s.phase == ST_DEV) && scl_fall && !start_det && !stop_det
    && s.busy_cnt > `BUSY_W'(1) |=> !s.sda_oe) else $error("acked while busy");
  page_roll_a: assert property (push_s.valid && push_s.ready
    |=> s.addr[9:4] == $past(s.addr[9:4])) else $error("page address left the page");
  write_timer_a: assert property (stop_det && s.wr_pending
    |=> s.busy_cnt == WR_CYCLES ##1 s.busy_cnt == WR_CYCLES - 1'b1) else $error("write timer wrong");
  seq_read_a: assert property (load_rd
    |=> s.addr == $past(s.addr) + 1'b1 && s.phase == ST_READ) else $error("read address not advanced");

  dev_ack_c: cover property (s.phase == ST_DEV_ACK && s.sda_oe);
  page_write_c: cover property (stop_det && s.wr_pending);
  seq_read_c: cover property (s.phase == ST_READ_ACK && scl_fall && s.mack);
endmodule

// >>> test/twowire_eeprom_pin_logic_tb_top.sv
// Purpose: self-checking bench for the two-wire memory target
// Assumes: shortened write time, host model on the far side
// Notes:   system clock 10 ns, serial clock 125 ns
`include "eeprom_regs.svh"
module twowire_eeprom_pin_logic_tb_top;
  timeunit 1ns;
  timeprecision 100ps;
  localparam int WCYC = 200; // short write time keeps the run brief

  logic       i_clock;
  logic       i_reset;
  logic       strap;
  logic       wp;
  logic       scl;
  logic       pull;
  logic       sda_oe;
  logic       sda_out;
  logic       busy;
  logic       ack;
  logic [7:0] d;
  wire        sda;
  int         num_errors;
  int         checks_done;
  int         cycles;
  int         n;

  // pull-up wins unless some party pulls low
  assign sda = !(sda_oe | pull);

  twowire_eeprom #(.P_WRITE_CYCLES(WCYC)) u_dut (
    .i_clock(i_clock), .i_reset(i_reset), .i_scl(scl), .i_sda(sda),
    .i_addr_select_strap(strap), .i_write_protect(wp),
    .o_sda_out(sda_out), .o_sda_oe(sda_oe), .o_write_busy(busy));

  twowire_host_model u_host (.o_scl(scl), .o_pull(pull), .i_sda(sda));

  initial begin
    i_clock = 1'b0;
    forever #5 i_clock = ~i_clock;
  end

  // hang guard well above the expected run
  always @(posedge i_clock) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      num_errors++;
      end_sim();
    end
  end

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checks_done++;
    if (got !== exp) begin
      $display("wrong value at %0t ns: got %h expected %h", $time, got, exp);
      num_errors++;
    end
  endtask

  task automatic sel(input logic [9:0] a, input logic s, input logic rw);
    u_host.frame_start();
    u_host.wbyte({`DEV_FAMILY, s, a[9:8], rw}, ack);
  endtask

  task automatic wr_seq(input logic [9:0] a, input int cnt, input logic [7:0] d0);
    sel(a, 1'b0, 1'b0);
    chk(8'(ack), 8'h01);
    u_host.wbyte(a[7:0], ack);
    for (int i = 0; i < cnt; i++) begin
      u_host.wbyte(d0 + 8'(i), ack);
      chk(8'(ack), 8'h01);
    end
    u_host.frame_stop();
  endtask

  // random read of a, then one sequential byte
  task automatic rd(input logic [9:0] a, input logic [7:0] e0, input logic [7:0] e1);
    sel(a, 1'b0, 1'b0);
    u_host.wbyte(a[7:0], ack);
    sel(a, 1'b0, 1'b1);
    u_host.rbyte(1'b0, d);
    chk(d, e0);
    u_host.rbyte(1'b1, d);
    chk(d, e1);
    u_host.frame_stop();
  endtask

  task automatic wait_write();
    n = 0;
    while (busy === 1'b1 && n < 1000) begin
      @(negedge i_clock);
      n++;
    end
  endtask

  task automatic t_byte();
    chk({6'h00, sda_oe, sda_out}, 8'h00);
    wr_seq(10'h000, 1, 8'hA5);
    chk(8'(busy), 8'h01);
    wait_write();
    chk(8'(n <= WCYC && n > WCYC - 20), 8'h01);
    $display("byte write test done");
  endtask

  task automatic t_page();
    wr_seq(10'h3F0, 16, 8'h40);
    sel(10'h3F0, 1'b0, 1'b0);
    chk(8'(ack), 8'h00);
    u_host.frame_stop();
    wait_write();
    rd(10'h3FF, 8'h4F, 8'hA5);
    rd(10'h3F0, 8'h40, 8'h41);
    $display("page write and read test done");
  endtask

  task automatic t_protect();
    @(negedge i_clock) wp = 1'b1;
    wr_seq(10'h000, 1, 8'h3C);
    repeat (5) @(negedge i_clock);
    chk(8'(busy), 8'h00);
    @(negedge i_clock) wp = 1'b0;
    rd(10'h3FF, 8'h4F, 8'hA5);
    $display("protect test done");
  endtask

  // low strap stands for an undriven pin elsewhere in the run
  task automatic t_strap();
    @(negedge i_clock) strap = 1'b1;
    sel(10'h000, 1'b0, 1'b0);
    chk(8'(ack), 8'h00);
    u_host.frame_stop();
    sel(10'h000, 1'b1, 1'b0);
    chk(8'(ack), 8'h01);
    u_host.frame_stop();
    @(negedge i_clock) strap = 1'b0;
    $display("strap select test done");
  endtask

  task automatic end_sim();
    $display("checks %0d, mismatches %0d", checks_done, num_errors);
    if (num_errors == 0 && checks_done > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  initial begin
    i_reset = 1'b1;
    strap = 1'b0;
    wp = 1'b0;
    num_errors = 0;
    checks_done = 0;
    cycles = 0;
    repeat (4) @(posedge i_clock);
    @(negedge i_clock) i_reset = 1'b0;
    repeat (5) @(negedge i_clock);
    t_byte();
    t_page();
    t_protect();
    t_strap();
    end_sim();
  end
endmodule

// >>> test/twowire_host_model.sv
// Purpose: bus controller model driving the serial clock and pulling data
// Assumes: 125 ns serial clock period, open-drain data wire with pull-up
// Notes:   tasks are called from the bench top; clock parks high when idle
module twowire_host_model (
  output logic      o_scl,  // serial clock
  output logic      o_pull, // high pulls the data wire low
  input  wire logic i_sda   // resolved data wire
);
  timeunit 1ns;
  timeprecision 100ps;

  // bus idles with clock high and data released
  initial begin
    o_scl  = 1'b1;
    o_pull = 1'b0;
  end

  // data moves only while clock is low, sampled mid high phase; 125 ns per bit
  // non-blocking drives keep a change that meets a clock edge behind the sampling
  task automatic bit_x(input logic b, output logic r);
    o_scl <= 1'b0;
    #20 o_pull <= !b;
    #42 o_scl <= 1'b1;
    #31 r = i_sda;
    #32;
  endtask

  // also serves as repeated start
  task automatic frame_start();
    o_scl <= 1'b0;
    #20 o_pull <= 1'b0;
    #42 o_scl <= 1'b1;
    #62 o_pull <= 1'b1;
    #62;
  endtask

  // ends with clock left high for the idle bus
  task automatic frame_stop();
    o_scl <= 1'b0;
    #20 o_pull <= 1'b1;
    #42 o_scl <= 1'b1;
    #62 o_pull <= 1'b0;
    #62;
  endtask

  task automatic wbyte(input logic [7:0] d, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bit_x(d[i], r);
    end
    bit_x(1'b1, r);
    ack = !r;
  endtask

  // last high leaves the ack slot released to end a read
  task automatic rbyte(input logic last, output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bit_x(1'b1, r);
      d[i] = r;
    end
    bit_x(last, r);
  endtask
endmodule
